// file: src/pcint_pkg.sv
// package for the pin change interrupt block: register map and layouts
// assumes a byte-wide register port with read data one cycle after strobe
package pcint_pkg;

   localparam int          NUM_PINS     = 6;
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 3;

   // register offsets
   localparam logic [2:0]  ADDR_RISE    = 3'h0;
   localparam logic [2:0]  ADDR_FALL    = 3'h1;
   localparam logic [2:0]  ADDR_FLAGS   = 3'h2;
   localparam logic [2:0]  ADDR_STATUS  = 3'h3;
   localparam logic [2:0]  ADDR_MASK    = 3'h4;

   // status / mask bit positions
   localparam int          STAT_SUMMARY = 0;
   localparam int          STAT_W       = 1;

   // reset values
   localparam logic [5:0]  ENABLE_RST   = 6'h00;
   localparam logic [5:0]  FLAGS_RST    = 6'h00;
   localparam logic [0:0]  STATUS_RST   = 1'h0;
   localparam logic [0:0]  MASK_RST     = 1'h0;
   localparam logic [7:0]  RDATA_RST    = 8'h00;

endpackage : pcint_pkg

// file: src/pcint_top.sv
// pin change interrupt: edge detection on six port pins, flags, interrupt
// assumes pins may be asynchronous; register port strobes are one cycle
// Functional notes
// - Each of six pins has a rising-edge enable bit in bits 5 to 0.
// - Each of the same pins has a falling-edge enable bit in bits 5 to 0.
// - An enabled edge sets the pin's flag and the summary change flag.
// - A flag sets on rising edge with rise enable or falling with fall.
// - With both enables clear a pin never sets its flag from activity.
// - Hardware only sets flags; software clears them by writing zero.
// - The flag bits are readable and writable by software as well.
// - Bits 7 and 6 of the three registers ignore writes and read zero.
// - All enable and flag bits reset to zero on every reset.
`timescale 1ns/1ns
`default_nettype none

module pcint_top
(
   // clock and reset
   input  wire logic                         clock_i,
   input  wire logic                         srst_i,
   // register port
   input  wire logic [pcint_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [pcint_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                         wr_i,
   input  wire logic                         rd_i,
   output logic      [pcint_pkg::DATA_W-1:0] rdata_o,
   // port pins
   input  wire logic [pcint_pkg::NUM_PINS-1:0] port_pin_i,
   // status
   output logic                              change_summary_flag_o,
   output logic                              irq_o
);

   localparam int N = pcint_pkg::NUM_PINS;

   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic [N-1:0] prev_q;
   logic [N-1:0] rising_edge_enable_q;
   logic [N-1:0] falling_edge_enable_q;
   logic [N-1:0] pin_change_flags_q;
   logic [N-1:0] edge_hit;
   logic [pcint_pkg::STAT_W-1:0] status_q;
   logic [pcint_pkg::STAT_W-1:0] mask_q;
   logic         summary;
   logic         summary_prev_q;
   logic         wr_rise;
   logic         wr_fall;
   logic         wr_flags;
   logic         wr_status;
   logic         wr_mask;

   assign wr_rise   = wr_i && (addr_i == pcint_pkg::ADDR_RISE);
   assign wr_fall   = wr_i && (addr_i == pcint_pkg::ADDR_FALL);
   assign wr_flags  = wr_i && (addr_i == pcint_pkg::ADDR_FLAGS);
   assign wr_status = wr_i && (addr_i == pcint_pkg::ADDR_STATUS);
   assign wr_mask   = wr_i && (addr_i == pcint_pkg::ADDR_MASK);

   // two-stage synchroniser, then previous-sample compare
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end
      else
      begin
         sync1_q <= port_pin_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // each edge is seen for exactly one cycle
   assign edge_hit = (rising_edge_enable_q & sync2_q & ~prev_q)
                   | (falling_edge_enable_q & ~sync2_q & prev_q);

   // enable registers
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         rising_edge_enable_q  <= pcint_pkg::ENABLE_RST;
         falling_edge_enable_q <= pcint_pkg::ENABLE_RST;
      end
      else
      begin
         if (wr_rise)
            rising_edge_enable_q <= wdata_i[N-1:0];
         if (wr_fall)
            falling_edge_enable_q <= wdata_i[N-1:0];
      end
   end

   // flags: software write applies, hardware set wins over a same-cycle clear
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         pin_change_flags_q <= pcint_pkg::FLAGS_RST;
      else if (wr_flags)
         pin_change_flags_q <= wdata_i[N-1:0] | edge_hit;
      else
         pin_change_flags_q <= pin_change_flags_q | edge_hit;
   end

   assign summary               = |pin_change_flags_q;
   assign change_summary_flag_o = summary;

   // sticky interrupt status: set on summary rising, write one to clear
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         summary_prev_q <= 1'b0;
         status_q       <= pcint_pkg::STATUS_RST;
      end
      else
      begin
         summary_prev_q <= summary;
         if (summary && !summary_prev_q)
            status_q[pcint_pkg::STAT_SUMMARY] <= 1'b1;
         else if (wr_status && wdata_i[pcint_pkg::STAT_SUMMARY])
            status_q[pcint_pkg::STAT_SUMMARY] <= 1'b0;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         mask_q <= pcint_pkg::MASK_RST;
      else if (wr_mask)
         mask_q <= wdata_i[pcint_pkg::STAT_W-1:0];
   end

   assign irq_o = |(status_q & mask_q);

   // read data valid the cycle after the strobe only; unmapped reads zero
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         rdata_o <= pcint_pkg::RDATA_RST;
      else if (!rd_i)
         rdata_o <= pcint_pkg::RDATA_RST;
      else
      begin
         unique case (addr_i)
            pcint_pkg::ADDR_RISE:   rdata_o <= {2'b00, rising_edge_enable_q};
            pcint_pkg::ADDR_FALL:   rdata_o <= {2'b00, falling_edge_enable_q};
            pcint_pkg::ADDR_FLAGS:  rdata_o <= {2'b00, pin_change_flags_q};
            pcint_pkg::ADDR_STATUS: rdata_o <= {7'h00, status_q};
            pcint_pkg::ADDR_MASK:   rdata_o <= {7'h00, mask_q};
            default:                rdata_o <= pcint_pkg::RDATA_RST;
         endcase
      end
   end

endmodule : pcint_top

`default_nettype wire

// file: verif/pcint_chk.sv
// checker: port timing of the pin change block
// assumes one clock, synchronous reset active high
`timescale 1ns/1ns
`default_nettype none
module pcint_chk
(
   // top ports
   input wire logic       clock_i, srst_i, wr_i, rd_i,
   input wire logic       change_summary_flag_o, irq_o,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i, rdata_o,
   input wire logic [5:0] port_pin_i
);
   wire s = change_summary_flag_o;
   wire wf = wr_i && addr_i == 3'h2;
   wire rf = rd_i && addr_i == 3'h2;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   AST_HI: assert property ($past(rd_i) |-> !rdata_o[7:6])
      else $error("top bits set");
   AST_IDLE: assert property (!$past(rd_i) |-> !rdata_o)
      else $error("idle data");
   AST_SUM: assert property ($past(rf) |-> |rdata_o == $past(s))
      else $error("summary");
   AST_RST: assert property ($past(srst_i) |-> !s && !irq_o)
      else $error("reset");
   AST_HOLD: assert property ($past(s) && !$past(wf) |-> s)
      else $error("flag lost");
   // pin sampled three edges before the summary is seen high
   AST_RISE: assert property ($rose(s) |-> $past(wf) ||
      $past(port_pin_i, 3) != $past(port_pin_i, 4)) else $error("rise");
   AST_WSET: assert property (wf && |wdata_i[5:0] |=> s)
      else $error("write set");
   AST_IRQ: assert property ($rose(irq_o) |-> $past(wr_i) || $past(s))
      else $error("irq cause");
   cover property ($rose(irq_o));
   cover property ($fell(s));
   cover property ($rose(s) && !$past(wf));
endmodule : pcint_chk
bind pcint_top pcint_chk C (.clock_i, .srst_i, .wr_i, .rd_i, .addr_i,
   .wdata_i, .rdata_o, .port_pin_i, .change_summary_flag_o, .irq_o);
`default_nettype wire

// file: verif/pcint_pins.sv
// pin model: six port pin levels
// assumes the bench picks levels; they move only after an edge
`timescale 1ns/1ns
`default_nettype none
module pcint_pins
(
   input wire logic       clock_i,
   input wire logic [5:0] lvl_i,
   output logic     [5:0] port_pin_o
);
   always_ff @(posedge clock_i) port_pin_o <= lvl_i;
endmodule : pcint_pins
`default_nettype wire

// file: verif/testbench.sv
// testbench: random pin edges against a flag model, registers, irq
// assumes the checker binds itself to the design top
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic       clock_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, sum, irq;
   logic [2:0] addr_i = 0;
   logic [7:0] wdata_i = 0, rdata_o;
   logic [5:0] lvl = 0, pin, d, re = 0, fe = 0, fl = 0;
   int         failures = 0, checks_done = 0, cyc = 0, i, seed = 32'h4ab1;
   pcint_top DUT (.clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .port_pin_i(pin), .change_summary_flag_o(sum), .irq_o(irq));
   pcint_pins P (.clock_i, .lvl_i(lvl), .port_pin_o(pin));
   initial forever #25 clock_i = ~clock_i;
   task chk(input logic [7:0] s, e, input string n);
      checks_done++;
      if (s !== e)
      begin
         failures++;
         $display("Error %s exp %h saw %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1;
      @(posedge clock_i);
      wr_i <= 0;
      #1;
   endtask : wr
   task rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1;
      @(posedge clock_i);
      rd_i <= 0;
      #1 chk(rdata_o, e, n);
   endtask : rd
   // wait covers sync, compare, set and the status stage
   task step(input logic [5:0] n);
      fl = fl | re & ~lvl & n | fe & lvl & ~n;
      lvl <= n;
      repeat (8) @(posedge clock_i);
      #1;
   endtask : step
   task test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         failures++;
         test_done;
      end
   end
   initial
   begin
      repeat (6) @(posedge clock_i);
      srst_i <= 0;
      for (i = 0; i < 6; i++)
         rd(3'(i), 8'h00, "reset");
      wr(0, 8'hff);
      wr(5, 8'hff);
      rd(0, 8'h3f, "rise en");
      rd(5, 0, "unmapped");
      $display("test registers done");
      for (i = 0; i < 60; i++)
      begin
         if (i % 10 == 0)
         begin
            re = 6'($random(seed));
            fe = 6'($random(seed));
            wr(0, {2'h3, re});
            wr(1, {2'h3, fe});
            rd(1, {2'h0, fe}, "fall en");
         end
         step(6'($random(seed)));
         if (i % 4 == 0)
         begin
            d = 6'($random(seed));
            wr(2, {2'h3, d});
            fl = d;
         end
         rd(2, {2'h0, fl}, "flags");
         chk(8'(sum), 8'(|fl), "summary");
      end
      $display("test edges done");
      re = '1;
      fe = '1;
      wr(0, 8'h3f);
      wr(1, 8'h3f);
      wr(2, 0);
      wr(3, 1);
      wr(4, 1);
      chk(8'(irq), 0, "irq idle");
      step(~lvl);
      chk(8'(irq), 1, "irq set");
      rd(2, {2'h0, fl}, "all flags");
      rd(3, 8'h01, "status");
      rd(4, 8'h01, "mask");
      wr(4, 0);
      chk(8'(irq), 0, "irq masked");
      wr(4, 1);
      wr(3, 1);
      chk(8'(irq), 0, "irq cleared");
      $display("test irq done");
      // mid-run reset, held long enough for the flag hold check
      @(posedge clock_i);
      srst_i <= 1;
      repeat (3) @(posedge clock_i);
      srst_i <= 0;
      for (i = 0; i < 6; i++)
         rd(3'(i), 8'h00, "reset again");
      chk(8'(sum), 8'h00, "summary reset");
      chk(8'(irq), 8'h00, "irq reset");
      $display("test reset done");
      test_done;
   end
endmodule : testbench
`default_nettype wire
